//--- hdl/alarm_enable_lane_polarity_regs.sv
// Implementation choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module alarm_enable_lane_polarity_regs #(
    parameter int ADDR_W = 8,
    parameter int TEMP_W = 3
) (
    // clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic SYS_RST_IN,
    // classic wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [ADDR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    // raw alarm sources, same clock, one-cycle pulses
    input wire logic [3:0] CSI_ERR_PULSE_IN,
    input wire logic [1:0] BC_ERR_PULSE_IN,
    // raw sensor sources, asynchronous levels
    input wire logic [TEMP_W-1:0] TEMP_CODE_IN,
    input wire logic [3:0] VOLT_ALARM_IN,
    // alarm reporting
    output logic [11:0] ALARM_OUT,
    output logic IRQ_OUT,
    // lane configuration to the receiver
    output logic [4:0] HS_LANE_INVERT_OUT,
    output logic LP_CLOCK_LANE_INVERT_OUT,
    output logic [3:0] LP_DATA_LANE_INVERT_OUT,
    output logic [6:0] HS_RX_DEBUG_OUT,
    output logic [6:0] LP_RX_DEBUG_OUT,
    output logic [3:0] LANE_TERMINATION_ENABLE_OUT
);

    // register map, one register per word index, byte-wide except 26 and 27, which are 12 bits
    //   1c csi error alarm enables, bits 3:0 gate the four receive errors
    //   1d sensor limit alarm enables, bits 5:0 gate the six limit alarms
    //   1e back-channel alarm enables, bits 1:0, bits 7:2 stored but unused
    //   1f spare read-write byte with no function
    //   20 high-speed lane invert, bits 4:0, bits 7:5 read as zero
    //   21 low-power lane invert, bit 4 clock lane, bits 3:0 data lanes
    //   22 high-speed receive debug, bits 6:0
    //   23 low-power receive debug, bits 6:0
    //   24 termination enables, bits 3:0 drive the lanes, bits 7:4 stored only
    //   25 spare, reads as zero and ignores writes
    //   26 sticky interrupt status, write one to clear
    //   27 interrupt mask, same layout as the status
    //   28 temperature threshold: bit 7 sensor on, bits 6:4 upper, bits 2:0 lower
    //   29 live sensor comparison flags, read only
    // byte address is four times the index; the low two address bits are ignored

    // status, mask and alarm output layout
    //   3:0 receive errors: 3 phy control, 2 header ecc, 1 checksum, 0 length
    //   9:4 sensor limits: 9 temp high, 8 temp low, 7 and 6 sensor b, 5 and 4 sensor a
    //   11:10 back-channel: 11 crc error, 10 link detect

    // known limits
    //   temperature code bits are synchronised one by one, so a code that
    //   changes while sampled may compare wrongly for one cycle
    //   sensor levels raise status only when level and enable both become true
    //   a clear and a new event in the same cycle leave the status bit set
    //   pulse alarms stand one cycle on the alarm output, sensor alarms follow the level
    //   debug registers exist for bring-up; software keeps them at zero otherwise
    //   a write to an unmapped index is acknowledged and dropped
    //   reads of unmapped indices and reserved bits return zero
    //   every request is acknowledged one cycle after it is taken
    //   a strobe still high after the acknowledge starts a new request
    //   unselected byte lanes keep their stored bits on a write
    //   a new threshold applies at once, with no guard against a false edge

    // all state of the block
    typedef struct packed {
        logic [TEMP_W-1:0] temp_meta;
        logic [TEMP_W-1:0] temp_sync;
        logic [3:0] volt_meta;
        logic [3:0] volt_sync;
        logic [7:0] csi_en;
        logic [7:0] sens_en;
        logic [7:0] bc_en;
        logic [7:0] rsvd_1f;
        logic [4:0] pol_sel;
        logic [7:0] lp_pol;
        logic [6:0] hs_dbg;
        logic [6:0] lp_dbg;
        logic [7:0] term;
        logic [7:0] thresh;
        logic [5:0] sens_prev;
        logic [11:0] int_stat;
        logic [11:0] int_mask;
        logic [11:0] alarm;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    state_t q;
    state_t d;

    logic [5:0] idx;
    logic req;
    logic wr;
    logic [31:0] bmask;
    logic [31:0] wdat;
    logic [5:0] sens_lvl;
    logic [5:0] sens_rep;
    logic [3:0] csi_rep;
    logic [1:0] bc_rep;
    logic [11:0] ev_set;
    logic [11:0] ev_clr;
    logic [31:0] rd;

    // register index from the word address
    assign idx = WB_ADR_IN[7:2];

    // a request is taken once, in the cycle before the acknowledge
    assign req = WB_CYC_IN & WB_STB_IN & ~q.ack;
    assign wr = req & WB_WE_IN;

    // byte lane mask built from the select lines
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign bmask[g*8 +: 8] = {8{WB_SEL_IN[g]}};
        end
    endgenerate

    // merged write value: unselected lanes keep the stored bits
    always_comb begin
        wdat = (rd & ~bmask) | (WB_DAT_IN & bmask);
    end

    // local copies of package positions for readability
    localparam int SENS_T_HIGH_BIT = alarm_regs_pkg::SENS_T_HIGH_BIT;
    localparam int SENS_T_LOW_BIT = alarm_regs_pkg::SENS_T_LOW_BIT;
    localparam int SENS_VB_HIGH_BIT = alarm_regs_pkg::SENS_VB_HIGH_BIT;
    localparam int SENS_VB_LOW_BIT = alarm_regs_pkg::SENS_VB_LOW_BIT;
    localparam int SENS_VA_HIGH_BIT = alarm_regs_pkg::SENS_VA_HIGH_BIT;
    localparam int SENS_VA_LOW_BIT = alarm_regs_pkg::SENS_VA_LOW_BIT;

    // live sensor flags; the two temperature comparisons are enabled by the threshold register
    always_comb begin
        sens_lvl = 6'h00;
        sens_lvl[SENS_T_HIGH_BIT] = q.thresh[alarm_regs_pkg::THR_ENABLE_BIT]
            & (q.temp_sync > q.thresh[alarm_regs_pkg::THR_HI_MSB:alarm_regs_pkg::THR_HI_LSB]);
        sens_lvl[SENS_T_LOW_BIT] = q.thresh[alarm_regs_pkg::THR_ENABLE_BIT]
            & (q.temp_sync < q.thresh[alarm_regs_pkg::THR_LO_MSB:alarm_regs_pkg::THR_LO_LSB]);
        sens_lvl[SENS_VB_HIGH_BIT] = q.volt_sync[SENS_VB_HIGH_BIT];
        sens_lvl[SENS_VB_LOW_BIT] = q.volt_sync[SENS_VB_LOW_BIT];
        sens_lvl[SENS_VA_HIGH_BIT] = q.volt_sync[SENS_VA_HIGH_BIT];
        sens_lvl[SENS_VA_LOW_BIT] = q.volt_sync[SENS_VA_LOW_BIT];
    end

    // csi error alarms gated by their enables
    always_comb begin
        csi_rep = 4'h0;
        csi_rep[alarm_regs_pkg::CSI_PHY_CTRL_BIT] = CSI_ERR_PULSE_IN[alarm_regs_pkg::CSI_PHY_CTRL_BIT]
            & q.csi_en[alarm_regs_pkg::CSI_PHY_CTRL_BIT];
        csi_rep[alarm_regs_pkg::CSI_ECC2_BIT] = CSI_ERR_PULSE_IN[alarm_regs_pkg::CSI_ECC2_BIT]
            & q.csi_en[alarm_regs_pkg::CSI_ECC2_BIT];
        csi_rep[alarm_regs_pkg::CSI_CHKSUM_BIT] = CSI_ERR_PULSE_IN[alarm_regs_pkg::CSI_CHKSUM_BIT]
            & q.csi_en[alarm_regs_pkg::CSI_CHKSUM_BIT];
        csi_rep[alarm_regs_pkg::CSI_LENGTH_BIT] = CSI_ERR_PULSE_IN[alarm_regs_pkg::CSI_LENGTH_BIT]
            & q.csi_en[alarm_regs_pkg::CSI_LENGTH_BIT];
    end

    // sensor alarms gated by their enables
    always_comb begin
        sens_rep = 6'h00;
        sens_rep[SENS_T_HIGH_BIT] = sens_lvl[SENS_T_HIGH_BIT] & q.sens_en[SENS_T_HIGH_BIT];
        sens_rep[SENS_T_LOW_BIT] = sens_lvl[SENS_T_LOW_BIT] & q.sens_en[SENS_T_LOW_BIT];
        sens_rep[SENS_VB_HIGH_BIT] = sens_lvl[SENS_VB_HIGH_BIT] & q.sens_en[SENS_VB_HIGH_BIT];
        sens_rep[SENS_VB_LOW_BIT] = sens_lvl[SENS_VB_LOW_BIT] & q.sens_en[SENS_VB_LOW_BIT];
        sens_rep[SENS_VA_HIGH_BIT] = sens_lvl[SENS_VA_HIGH_BIT] & q.sens_en[SENS_VA_HIGH_BIT];
        sens_rep[SENS_VA_LOW_BIT] = sens_lvl[SENS_VA_LOW_BIT] & q.sens_en[SENS_VA_LOW_BIT];
    end

    // back-channel alarms gated by their enables
    always_comb begin
        bc_rep = 2'h0;
        bc_rep[alarm_regs_pkg::BC_CRC_BIT] = BC_ERR_PULSE_IN[alarm_regs_pkg::BC_CRC_BIT]
            & q.bc_en[alarm_regs_pkg::BC_CRC_BIT];
        bc_rep[alarm_regs_pkg::BC_LINK_BIT] = BC_ERR_PULSE_IN[alarm_regs_pkg::BC_LINK_BIT]
            & q.bc_en[alarm_regs_pkg::BC_LINK_BIT];
    end

    // interrupt events: pulses directly, sensor levels on their rising edge
    always_comb begin
        ev_set = 12'h000;
        ev_set[alarm_regs_pkg::STAT_CSI_LO +: alarm_regs_pkg::CSI_N] = csi_rep;
        ev_set[alarm_regs_pkg::STAT_SENS_LO +: alarm_regs_pkg::SENS_N] = sens_rep & ~q.sens_prev;
        ev_set[alarm_regs_pkg::STAT_BC_LO +: alarm_regs_pkg::BC_N] = bc_rep;
    end

    // write-one-to-clear request on the status register
    // only selected lanes count: merging stored bits in would clear every set flag
    assign ev_clr = (wr && idx == alarm_regs_pkg::IDX_INT_STAT) ? (WB_DAT_IN[11:0] & bmask[11:0]) : 12'h000;

    // read multiplexer; unmapped and reserved-read-zero bits give zero
    always_comb begin
        rd = 32'h0000_0000;
        case (idx)
            alarm_regs_pkg::IDX_CSI_EN: begin
                // all eight bits read back, spares included
                rd[7:0] = q.csi_en;
            end
            alarm_regs_pkg::IDX_SENS_EN: begin
                // sensor limit enables
                rd[7:0] = q.sens_en;
            end
            alarm_regs_pkg::IDX_BC_EN: begin
                // back-channel enables, upper bits stored only
                rd[7:0] = q.bc_en;
            end
            alarm_regs_pkg::IDX_RSVD_1F: begin
                // spare byte
                rd[7:0] = q.rsvd_1f;
            end
            alarm_regs_pkg::IDX_POL_SEL: begin
                // high-speed invert, bits 7:5 read as zero
                rd[4:0] = q.pol_sel;
            end
            alarm_regs_pkg::IDX_LP_POL: begin
                // low-power invert
                rd[7:0] = q.lp_pol;
            end
            alarm_regs_pkg::IDX_HS_DBG: begin
                // high-speed debug, bit 7 reads as zero
                rd[6:0] = q.hs_dbg;
            end
            alarm_regs_pkg::IDX_LP_DBG: begin
                // low-power debug, bit 7 reads as zero
                rd[6:0] = q.lp_dbg;
            end
            alarm_regs_pkg::IDX_TERM: begin
                // termination enables with stored upper bits
                rd[7:0] = q.term;
            end
            alarm_regs_pkg::IDX_INT_STAT: begin
                // sticky status
                rd[11:0] = q.int_stat;
            end
            alarm_regs_pkg::IDX_INT_MASK: begin
                // interrupt mask
                rd[11:0] = q.int_mask;
            end
            alarm_regs_pkg::IDX_THRESH: begin
                // temperature threshold
                rd[7:0] = q.thresh;
            end
            alarm_regs_pkg::IDX_SENS_STAT: begin
                // live comparison flags, not sticky
                rd[5:0] = sens_lvl;
            end
            default: begin
                // unmapped indices and the spare at 25 read as zero
                rd = 32'h0000_0000;
            end
        endcase
    end

    // next state
    always_comb begin
        d = q;
        // two-stage synchronisers for the asynchronous sensor inputs
        // only the second stage feeds logic, so metastability stays in the first
        d.temp_meta = TEMP_CODE_IN;
        d.temp_sync = q.temp_meta;
        d.volt_meta = VOLT_ALARM_IN;
        d.volt_sync = q.volt_meta;
        // alarm report and edge history
        d.sens_prev = sens_rep;
        d.alarm = {bc_rep, sens_rep, csi_rep};
        // sticky status: a new event wins over a clear in the same cycle
        d.int_stat = (q.int_stat & ~ev_clr) | ev_set;
        // bus handshake: acknowledge one cycle after the request
        d.ack = req;
        if (req) begin
            d.rdata = rd;
        end
        // register writes
        if (wr) begin
            case (idx)
                alarm_regs_pkg::IDX_CSI_EN: begin
                    // receive error enables
                    d.csi_en = wdat[7:0];
                end
                alarm_regs_pkg::IDX_SENS_EN: begin
                    // sensor limit enables
                    d.sens_en = wdat[7:0];
                end
                alarm_regs_pkg::IDX_BC_EN: begin
                    // back-channel enables
                    d.bc_en = wdat[7:0];
                end
                alarm_regs_pkg::IDX_RSVD_1F: begin
                    // spare byte
                    d.rsvd_1f = wdat[7:0];
                end
                alarm_regs_pkg::IDX_POL_SEL: begin
                    // only the five lane bits are kept
                    d.pol_sel = wdat[4:0];
                end
                alarm_regs_pkg::IDX_LP_POL: begin
                    // low-power invert
                    d.lp_pol = wdat[7:0];
                end
                alarm_regs_pkg::IDX_HS_DBG: begin
                    // high-speed debug
                    d.hs_dbg = wdat[6:0];
                end
                alarm_regs_pkg::IDX_LP_DBG: begin
                    // low-power debug
                    d.lp_dbg = wdat[6:0];
                end
                alarm_regs_pkg::IDX_TERM: begin
                    // termination enables
                    d.term = wdat[7:0];
                end
                alarm_regs_pkg::IDX_INT_MASK: begin
                    // interrupt mask
                    d.int_mask = wdat[11:0];
                end
                alarm_regs_pkg::IDX_THRESH: begin
                    // temperature threshold
                    d.thresh = wdat[7:0];
                end
                default: begin
                    // status clears go through ev_clr; other indices ignore writes
                    d.ack = req;
                end
            endcase
        end
        // synchronous reset to the power-up values
        // it comes last so it overrides any write in the same cycle
        if (SYS_RST_IN) begin
            d = '0;
            d.csi_en = alarm_regs_pkg::RST_CSI_EN;
            d.sens_en = alarm_regs_pkg::RST_SENS_EN;
            d.bc_en = alarm_regs_pkg::RST_BC_EN;
            d.rsvd_1f = alarm_regs_pkg::RST_RSVD_1F;
            d.pol_sel = alarm_regs_pkg::RST_POL_SEL;
            d.lp_pol = alarm_regs_pkg::RST_LP_POL;
            d.hs_dbg = alarm_regs_pkg::RST_DBG;
            d.lp_dbg = alarm_regs_pkg::RST_DBG;
            d.term = alarm_regs_pkg::RST_TERM;
            d.thresh = alarm_regs_pkg::RST_THRESH;
        end
    end

    // state register
    // reset is folded into the next-state logic, so this is a plain register
    always_ff @(posedge CORE_CLK_IN) begin
        q <= d;
    end

    // bus outputs
    assign WB_ACK_OUT = q.ack;
    assign WB_DAT_OUT = q.rdata;

    // alarm and interrupt outputs
    assign ALARM_OUT = q.alarm;
    assign IRQ_OUT = |(q.int_stat & q.int_mask);

    // lane configuration outputs
    assign HS_LANE_INVERT_OUT = q.pol_sel;
    assign LP_CLOCK_LANE_INVERT_OUT = q.lp_pol[4];
    assign LP_DATA_LANE_INVERT_OUT = q.lp_pol[3:0];
    assign HS_RX_DEBUG_OUT = q.hs_dbg;
    assign LP_RX_DEBUG_OUT = q.lp_dbg;
    assign LANE_TERMINATION_ENABLE_OUT = q.term[alarm_regs_pkg::TERM_N-1:0];

endmodule // alarm_enable_lane_polarity_regs
`default_nettype wire

//--- hdl/alarm_regs_pkg.sv
package alarm_regs_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CSI_EN = 6'h1c;
    localparam logic [5:0] IDX_SENS_EN = 6'h1d;
    localparam logic [5:0] IDX_BC_EN = 6'h1e;
    localparam logic [5:0] IDX_RSVD_1F = 6'h1f;
    localparam logic [5:0] IDX_POL_SEL = 6'h20;
    localparam logic [5:0] IDX_LP_POL = 6'h21;
    localparam logic [5:0] IDX_HS_DBG = 6'h22;
    localparam logic [5:0] IDX_LP_DBG = 6'h23;
    localparam logic [5:0] IDX_TERM = 6'h24;
    localparam logic [5:0] IDX_RSVD_25 = 6'h25;
    localparam logic [5:0] IDX_INT_STAT = 6'h26;
    localparam logic [5:0] IDX_INT_MASK = 6'h27;
    localparam logic [5:0] IDX_THRESH = 6'h28;
    localparam logic [5:0] IDX_SENS_STAT = 6'h29;
    // reset values
    localparam logic [7:0] RST_CSI_EN = 8'h3f;
    localparam logic [7:0] RST_SENS_EN = 8'h00;
    localparam logic [7:0] RST_BC_EN = 8'h00;
    localparam logic [7:0] RST_RSVD_1F = 8'h00;
    localparam logic [4:0] RST_POL_SEL = 5'h00;
    localparam logic [7:0] RST_LP_POL = 8'h00;
    localparam logic [6:0] RST_DBG = 7'h00;
    localparam logic [7:0] RST_TERM = 8'h00;
    localparam logic [7:0] RST_THRESH = 8'he2;
    // csi alarm bit positions
    localparam int CSI_PHY_CTRL_BIT = 3;
    localparam int CSI_ECC2_BIT = 2;
    localparam int CSI_CHKSUM_BIT = 1;
    localparam int CSI_LENGTH_BIT = 0;
    // sensor alarm bit positions
    localparam int SENS_T_HIGH_BIT = 5;
    localparam int SENS_T_LOW_BIT = 4;
    localparam int SENS_VB_HIGH_BIT = 3;
    localparam int SENS_VB_LOW_BIT = 2;
    localparam int SENS_VA_HIGH_BIT = 1;
    localparam int SENS_VA_LOW_BIT = 0;
    // back-channel alarm bit positions
    localparam int BC_CRC_BIT = 1;
    localparam int BC_LINK_BIT = 0;
    // threshold register fields
    localparam int THR_ENABLE_BIT = 7;
    localparam int THR_HI_MSB = 6;
    localparam int THR_HI_LSB = 4;
    localparam int THR_LO_MSB = 2;
    localparam int THR_LO_LSB = 0;
    // field widths and interrupt status layout
    localparam int CSI_N = 4;
    localparam int SENS_N = 6;
    localparam int BC_N = 2;
    localparam int ALARM_N = 12;
    localparam int STAT_CSI_LO = 0;
    localparam int STAT_SENS_LO = 4;
    localparam int STAT_BC_LO = 10;
    localparam int POL_N = 5;
    localparam int DBG_N = 7;
    localparam int TERM_N = 4;
endpackage

//--- sim/alarm_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module alarm_regs_asserts #(
    parameter int ADDR_W = 8,
    parameter int TEMP_W = 3
) (
    // clock, reset and bus
    input wire logic CORE_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [ADDR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    input wire logic WB_ACK_OUT,
    // alarms and lane settings
    input wire logic [3:0] CSI_ERR_PULSE_IN,
    input wire logic [1:0] BC_ERR_PULSE_IN,
    input wire logic [11:0] ALARM_OUT,
    input wire logic [4:0] HS_LANE_INVERT_OUT,
    input wire logic LP_CLOCK_LANE_INVERT_OUT,
    input wire logic [3:0] LP_DATA_LANE_INVERT_OUT,
    input wire logic [6:0] HS_RX_DEBUG_OUT,
    input wire logic [3:0] LANE_TERMINATION_ENABLE_OUT
);
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    // low-byte write taken at this edge, and its register index
    logic wr_lo;
    logic [5:0] idx;
    assign wr_lo = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && WB_WE_IN && WB_SEL_IN[0];
    assign idx = WB_ADR_IN[7:2];
    // enables as last written, to predict the gated pulse alarms
    logic [3:0] csi_en_seen;
    logic [1:0] bc_en_seen;
    always_ff @(posedge CORE_CLK_IN) begin
        if (SYS_RST_IN) begin
            csi_en_seen <= 4'hf;
            bc_en_seen <= 2'h0;
        end else if (wr_lo && idx == alarm_regs_pkg::IDX_CSI_EN) begin
            csi_en_seen <= WB_DAT_IN[3:0];
        end else if (wr_lo && idx == alarm_regs_pkg::IDX_BC_EN) begin
            bc_en_seen <= WB_DAT_IN[1:0];
        end
    end
    // register writes land in the lane outputs one edge later
    chk_hs_pol_write: assert property (
        wr_lo && idx == alarm_regs_pkg::IDX_POL_SEL |=> HS_LANE_INVERT_OUT == $past(WB_DAT_IN[4:0]))
        else $error("high-speed lane invert not loaded");
    chk_hs_pol_hold: assert property (
        !(wr_lo && idx == alarm_regs_pkg::IDX_POL_SEL) |=> $stable(HS_LANE_INVERT_OUT))
        else $error("high-speed lane invert changed without a write");
    chk_lp_pol_write: assert property (
        wr_lo && idx == alarm_regs_pkg::IDX_LP_POL |=>
        {LP_CLOCK_LANE_INVERT_OUT, LP_DATA_LANE_INVERT_OUT} == $past(WB_DAT_IN[4:0]))
        else $error("low-power lane invert not loaded");
    chk_term_write: assert property (
        wr_lo && idx == alarm_regs_pkg::IDX_TERM |=> LANE_TERMINATION_ENABLE_OUT == $past(WB_DAT_IN[3:0]))
        else $error("termination enable not loaded");
    chk_dbg_write: assert property (
        wr_lo && idx == alarm_regs_pkg::IDX_HS_DBG |=> HS_RX_DEBUG_OUT == $past(WB_DAT_IN[6:0]))
        else $error("high-speed debug field not loaded");
    // csi and back-channel alarm bits follow their gated source pulse one edge later; reset clears the outputs
    chk_csi_gate: assert property (
        ALARM_OUT[3:0] == $past(CSI_ERR_PULSE_IN & csi_en_seen))
        else $error("csi alarm without a source pulse");
    chk_bc_gate: assert property (
        ALARM_OUT[11:10] == $past(BC_ERR_PULSE_IN & bc_en_seen))
        else $error("back-channel alarm without a source pulse");
    chk_reset_clear: assert property (disable iff (1'b0)
        $past(SYS_RST_IN) |-> HS_LANE_INVERT_OUT == 5'h00 && LP_DATA_LANE_INVERT_OUT == 4'h0 &&
        !LP_CLOCK_LANE_INVERT_OUT && LANE_TERMINATION_ENABLE_OUT == 4'h0 && ALARM_OUT == 12'h000)
        else $error("outputs not cleared by reset");
endmodule // alarm_regs_asserts
bind alarm_enable_lane_polarity_regs alarm_regs_asserts #(.ADDR_W(ADDR_W), .TEMP_W(TEMP_W)) chk_i (
    .CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
    .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
    .WB_ACK_OUT(WB_ACK_OUT), .CSI_ERR_PULSE_IN(CSI_ERR_PULSE_IN), .BC_ERR_PULSE_IN(BC_ERR_PULSE_IN),
    .ALARM_OUT(ALARM_OUT), .HS_LANE_INVERT_OUT(HS_LANE_INVERT_OUT),
    .LP_CLOCK_LANE_INVERT_OUT(LP_CLOCK_LANE_INVERT_OUT), .LP_DATA_LANE_INVERT_OUT(LP_DATA_LANE_INVERT_OUT),
    .HS_RX_DEBUG_OUT(HS_RX_DEBUG_OUT), .LANE_TERMINATION_ENABLE_OUT(LANE_TERMINATION_ENABLE_OUT));
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // stimulus, observed outputs and model state
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, lpclk;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, csi = 4'h0, volt = 4'h0, lpdat, term;
    logic [1:0] bc = 2'h0;
    logic [2:0] temp = 3'h4;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [11:0] alarm;
    logic [4:0] hsinv;
    logic [6:0] hsdbg, lpdbg;
    logic [7:0] mdl [10];
    logic [7:0] rmask [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h1f, 8'hff, 8'h7f, 8'h7f, 8'hff, 8'h00};
    integer seed = 32'h1183, err_count = 0, total_checks = 0, i, k;
    alarm_enable_lane_polarity_regs dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(dat_o), .WB_ACK_OUT(ack),
        .CSI_ERR_PULSE_IN(csi), .BC_ERR_PULSE_IN(bc), .TEMP_CODE_IN(temp), .VOLT_ALARM_IN(volt),
        .ALARM_OUT(alarm), .IRQ_OUT(irq), .HS_LANE_INVERT_OUT(hsinv), .LP_CLOCK_LANE_INVERT_OUT(lpclk),
        .LP_DATA_LANE_INVERT_OUT(lpdat), .HS_RX_DEBUG_OUT(hsdbg), .LP_RX_DEBUG_OUT(lpdbg),
        .LANE_TERMINATION_ENABLE_OUT(term));
    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    // verdict and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // compare a register read
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    // compare port outputs
    task automatic cmp_port(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: port %h expected %h", $time, got, exp);
        end
    endtask
    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d, input logic [3:0] s);
        integer n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        sel <= s;
        for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clk);
        if (n == 20) begin
            err_count++;
            conclude();
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // one-cycle source pulses, alarm output checked one edge later
    task automatic pulse(input logic [3:0] c, input logic [1:0] b, input logic [11:0] exp);
        @(posedge clk);
        csi <= c;
        bc <= b;
        @(posedge clk);
        csi <= 4'h0;
        bc <= 2'h0;
        @(posedge clk);
        cmp_port(alarm, exp);
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 10; i++) begin
            mdl[i] = (i == 0) ? 8'h3f : 8'h00;
            wb(1'b0, 6'h1c + 6'(i), 32'h0, 4'h0);
            cmp_reg(rdat, {24'h0, mdl[i]});
        end
        // random contents, read back and seen at the lane outputs
        for (k = 0; k < 3; k++) begin
            for (i = 0; i < 10; i++) begin
                wb(1'b1, 6'h1c + 6'(i), $random(seed), 4'h1);
                mdl[i] = wdat[7:0] & rmask[i];
            end
            wb(1'b1, 6'h20, ~wdat, 4'h0);
            for (i = 0; i < 10; i++) begin
                wb(1'b0, 6'h1c + 6'(i), 32'h0, 4'h0);
                cmp_reg(rdat, {24'h0, mdl[i]});
            end
            cmp_port({hsinv, lpclk, lpdat, hsdbg, lpdbg, term},
                {mdl[4][4:0], mdl[5][4:0], mdl[6][6:0], mdl[7][6:0], mdl[8][3:0]});
        end
        wb(1'b1, 6'h22, 32'h0, 4'h1);
        cmp_port(hsdbg, 32'h0);
        wb(1'b1, 6'h3f, 32'hff, 4'hf);
        wb(1'b0, 6'h3f, 32'h0, 4'h0);
        cmp_reg(rdat, 32'h0);
        // csi and back-channel alarms, interrupt raise, mask and clear
        wb(1'b1, 6'h1c, 32'h0f, 4'h1);
        wb(1'b1, 6'h1e, 32'h03, 4'h1);
        wb(1'b1, 6'h27, 32'h0, 4'h3);
        wb(1'b1, 6'h26, 32'hfff, 4'h3);
        for (i = 0; i < 4; i++) pulse(4'h1 << i, 2'h0, 12'h001 << i);
        pulse(4'h0, 2'h3, 12'hc00);
        wb(1'b0, 6'h26, 32'h0, 4'h0);
        cmp_reg(rdat, 32'hc0f);
        cmp_port(irq, 32'h0);
        wb(1'b1, 6'h27, 32'h001, 4'h3);
        cmp_port(irq, 32'h1);
        wb(1'b1, 6'h26, 32'h001, 4'h3);
        cmp_port(irq, 32'h0);
        wb(1'b1, 6'h1c, 32'h0, 4'h1);
        wb(1'b1, 6'h1e, 32'h0, 4'h1);
        pulse(4'hf, 2'h3, 12'h000);
        wb(1'b0, 6'h26, 32'h0, 4'h0);
        cmp_reg(rdat, 32'hc0e);
        wb(1'b1, 6'h1c, 32'h08, 4'h1);
        pulse(4'hf, 2'h3, 12'h008);
        // sensor levels gated by their enables
        volt <= 4'hf;
        temp <= 3'h7;
        wb(1'b1, 6'h1d, 32'h00, 4'h1);
        repeat (5) @(posedge clk);
        cmp_port(alarm, 32'h000);
        wb(1'b1, 6'h1d, 32'h2f, 4'h1);
        repeat (5) @(posedge clk);
        cmp_port(alarm, 32'h2f0);
        wb(1'b0, 6'h29, 32'h0, 4'h0);
        cmp_reg(rdat, 32'h2f);
        volt <= 4'h5;
        temp <= 3'h0;
        wb(1'b1, 6'h1d, 32'h3f, 4'h1);
        repeat (5) @(posedge clk);
        cmp_port(alarm, 32'h150);
        wb(1'b1, 6'h26, 32'hfff, 4'h0);
        wb(1'b0, 6'h26, 32'h0, 4'h0);
        cmp_reg(rdat, 32'hffe);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
